/* verilog/radio_spi_pkg.sv */
// Constants, field layouts and state codes of the radio serial slave.
// Assumes a single design clock; the serial pins are sampled in that domain.
`default_nettype none
package radio_spi_pkg;

  // ****************************************************************
  // Header byte layout and address map
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam int HDR_RW = 7;
  localparam int HDR_BURST = 6;
  localparam logic [5:0] ADDR_STROBE_LO = 6'h30;
  localparam logic [5:0] ADDR_STROBE_HI = 6'h3d;
  localparam logic [5:0] ADDR_FIFO = 6'h3f;
  localparam logic [5:0] ADDR_STEP = 6'h01;

  // ****************************************************************
  // Status byte layout and bit counting
  // ****************************************************************
  localparam int ST_RDY_BIT = 7;
  localparam logic [3:0] FILL_MAX = 4'hf;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [6:0] COUNT_ZERO = 7'h00;

  // ****************************************************************
  // Radio main state codes and serial phases
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_TX = 3'b010,
    ST_SYNTH_TX_READY = 3'b011,
    ST_CALIBRATE = 3'b100,
    ST_SETTLING = 3'b101,
    ST_RX_OVERRUN = 3'b110,
    ST_TX_UNDERRUN = 3'b111
  } radio_state_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HEADER = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

endpackage
`default_nettype wire

/* verilog/radio_spi_slave_status.sv */
// Serial slave front end of the radio: header parse, status byte, register
// and FIFO byte transfers. Assumes the radio core sits on clk and that the
// serial clock runs well below a quarter of the clk rate.
//
// How it works
// [RL1] Bytes move most significant bit first, both directions.
// [RL2] Every transaction opens with header: read/write, burst flag, 6-bit address.
// [RL3] Master keeps chip select low for each whole transfer.
// [RL4] Chip select rising mid header or data byte abandons that transfer.
// [RL5] Master waits for serial out low before shifting the header.
// [RL6] Select falling with crystal running drives serial out low immediately.
// [RL7] Status byte shifts out while header, data or strobe shifts in.
// [RL8] Status bit 7 high until crystal stable, low in normal access.
// [RL9] Status bits 6 to 4 carry the main radio state code.
// [RL10] Codes: 010 transmit, 011 synth ready for transmit, 100 calibration.
// [RL11] Code 111 after transmit buffer underrun, cleared by flush command.
// [RL12] Transitional settling or calibrate may be reported as idle.
// [RL13] Read headers: fill count gives receive bytes available.
// [RL14] Write headers: fill count gives transmit positions free.
// [RL15] Fill count saturates at 15 meaning fifteen or more.
// [RL16] Configuration registers load defaults on chip reset.
// [RL17] Host rewrites non-default registers after each reset.
// [RL18] Host changes frequency and channel only in idle.
// [RL19] Host reads useful bytes then flushes after receive overrun.
// [RL20] One serial slave carries configuration and payload data.
// [RL21] Codes: 000 idle, 001 receive, 101 settling, 110 receive overrun.
// [RL22] Sample serial in on rising clock, change serial out on falling.
// [RL23] Burst header loads address counter, incremented each byte until deselect; code holds it at 0x3F and ends the burst after a byte at 0x30-0x3D.
// [RL24] Addresses 0x30-0x3D: burst selects status read, else command strobe.
// [RL25] Address 0x3F reaches transmit buffer on write, receive on read.
// [RL26] Writes return status every byte; reads only during header.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_slave_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  input wire logic crystalNotReady,
  input wire radio_spi_pkg::radio_state_t radioState,
  input wire logic stateTransitional,
  input wire logic [6:0] rxCount,
  input wire logic [6:0] txFree,
  output logic [radio_spi_pkg::ADDR_W-1:0] regAddr,
  output logic regWrValid,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  output logic strobeValid,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady
);
  import radio_spi_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic sclkS1_q, sclkS2_q, sclkS3_q;
  logic csS1_q, csS2_q, csS3_q;
  logic siS1_q, siS2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sclkS1_q, sclkS2_q, sclkS3_q} <= 3'h0;
      {csS1_q, csS2_q, csS3_q} <= 3'h7;
      {siS1_q, siS2_q} <= 2'h0;
    end else begin
      {sclkS1_q, sclkS2_q, sclkS3_q} <= {serialClk, sclkS1_q, sclkS2_q};
      {csS1_q, csS2_q, csS3_q} <= {chipSelectN, csS1_q, csS2_q};
      {siS1_q, siS2_q} <= {serialIn, siS1_q};
    end
  end

  wire sclkRise = sclkS2_q & ~sclkS3_q; // [RL22]
  wire sclkFall = ~sclkS2_q & sclkS3_q; // [RL22]
  wire csFall = ~csS2_q & csS3_q;

  // ****************************************************************
  // Status byte
  // ****************************************************************
  function automatic logic [3:0] fill15(input logic [6:0] n);
    fill15 = (n[6:4] != 3'h0) ? FILL_MAX : n[3:0]; // [RL15]
  endfunction

  phase_t phase_q;
  logic [2:0] bitCnt_q;
  logic [6:0] inShift_q;
  logic rw_q, burst_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] outByte_q;
  logic useStatus_q;
  logic v0_q, v1_q;
  logic stepDue_q;
  logic [7:0] d1_q;

  wire [1:0] bufOcc = {1'b0, v0_q} + {1'b0, v1_q};
  wire [6:0] occWide = {5'h0, bufOcc};
  // Bytes parked in the buffer are not yet in the transmit FIFO, so they
  // are taken off the free count, which reports zero once they use up all of txFree.
  wire [6:0] txFreeAdj = (txFree > occWide) ? (txFree - occWide) : COUNT_ZERO;
  wire [3:0] fillCount = rw_q ? fill15(rxCount) : fill15(txFreeAdj); // [RL13] [RL14]
  wire hideState = stateTransitional &&
                   (radioState == ST_SETTLING || radioState == ST_CALIBRATE);
  wire [2:0] stateShown = hideState ? ST_IDLE : radioState; // [RL12]
  wire [7:0] statusByte = {crystalNotReady, stateShown, fillCount}; // [RL8] [RL9] [RL10] [RL11] [RL21]

  // ****************************************************************
  // Byte framing and decode
  // ****************************************************************
  wire [7:0] inByte = {inShift_q, siS2_q}; // [RL1]
  wire byteDone = sclkRise && (bitCnt_q == 3'h7) && !csS2_q;
  wire [ADDR_W-1:0] hdrAddr = inByte[ADDR_W-1:0];
  wire hdrInRange = hdrAddr >= ADDR_STROBE_LO && hdrAddr <= ADDR_STROBE_HI;
  wire hdrStrobe = hdrInRange && !inByte[HDR_BURST]; // [RL24]
  wire addrStatus = addr_q >= ADDR_STROBE_LO && addr_q <= ADDR_STROBE_HI;
  wire addrFifo = addr_q == ADDR_FIFO;
  wire headerDone = byteDone && phase_q == PH_HEADER; // [RL2]
  wire dataDone = byteDone && phase_q == PH_DATA;
  wire burstGo = burst_q && !addrStatus; // [RL24]
  wire txPush = dataDone && !rw_q && addrFifo; // [RL25]
  wire cfgWrite = dataDone && !rw_q && !addrFifo && !addrStatus;
  wire loadNext = sclkFall && bitCnt_q == BIT_FIRST && !csS2_q;
  wire loadRead = loadNext && phase_q == PH_DATA && rw_q; // [RL26]
  wire popRx = loadRead && addrFifo && rxValid; // [RL25]
  wire [7:0] readByte = addrFifo ? (rxValid ? rxData : BYTE_ZERO) : regRdData;
  wire [7:0] curByte = useStatus_q ? statusByte : outByte_q; // [RL7]
  wire [2:0] outIdx = 3'h7 - bitCnt_q;
  wire waitFirst = phase_q == PH_HEADER && bitCnt_q == BIT_FIRST && !sclkS2_q;

  // ****************************************************************
  // Serial state machine
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      bitCnt_q <= BIT_FIRST;
      inShift_q <= 7'h00;
      rw_q <= 1'b0;
      burst_q <= 1'b0;
      addr_q <= '0; // [RL16]
    end else if (csS2_q) begin
      phase_q <= PH_IDLE; // [RL4]
      bitCnt_q <= BIT_FIRST; // [RL4]
    end else if (csFall) begin
      phase_q <= PH_HEADER;
      bitCnt_q <= BIT_FIRST;
    end else if (sclkRise) begin
      bitCnt_q <= bitCnt_q + BIT_STEP;
      inShift_q <= inByte[6:0]; // [RL1]
      if (phase_q == PH_HEADER && bitCnt_q == BIT_FIRST) begin
        rw_q <= siS2_q; // [RL2]
      end
      if (headerDone) begin
        burst_q <= inByte[HDR_BURST]; // [RL2]
        addr_q <= hdrAddr; // [RL23]
        phase_q <= hdrStrobe ? PH_HEADER : PH_DATA; // [RL24]
      end else if (dataDone && !burstGo) begin
        phase_q <= PH_HEADER;
      end
    end else if (stepDue_q) begin
      // The step waits a cycle so that a write pulse still meets its own address.
      addr_q <= addr_q + ADDR_STEP; // [RL23]
    end
  end

  // ****************************************************************
  // Serial out pin
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialOut <= 1'b0;
      serialOutOe <= 1'b0;
      useStatus_q <= 1'b1;
      outByte_q <= BYTE_ZERO;
    end else if (csS2_q) begin
      serialOutOe <= 1'b0;
      useStatus_q <= 1'b1;
    end else if (csFall || waitFirst) begin
      // Crystal readiness is tracked until the first clock edge. [RL6] [RL5]
      serialOutOe <= 1'b1;
      serialOut <= statusByte[ST_RDY_BIT]; // [RL6] [RL8]
      useStatus_q <= 1'b1;
    end else if (loadNext) begin
      useStatus_q <= !loadRead; // [RL26]
      outByte_q <= readByte;
      serialOut <= loadRead ? readByte[7] : statusByte[ST_RDY_BIT]; // [RL1] [RL7]
    end else if (sclkFall) begin
      serialOut <= curByte[outIdx]; // [RL22]
    end
  end

  // ****************************************************************
  // Register, strobe and receive ports
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regWrValid <= 1'b0;
      regWrData <= BYTE_ZERO;
      strobeValid <= 1'b0;
      rxReady <= 1'b0;
      stepDue_q <= 1'b0;
    end else begin
      stepDue_q <= dataDone && burstGo && !addrFifo; // [RL23]
      regWrValid <= cfgWrite; // [RL20]
      if (cfgWrite) begin
        regWrData <= inByte;
      end
      strobeValid <= headerDone && hdrStrobe; // [RL24]
      rxReady <= popRx; // [RL25]
    end
  end

  // The register address output is the address counter itself.
  assign regAddr = addr_q;

  // ****************************************************************
  // Two-entry transmit buffer
  // ****************************************************************
  // A full buffer refuses the byte unless its head pops in the same cycle; the host was told zero free only if txFree was two or less.
  wire bufPop = v0_q && txReady;
  wire bufPush = txPush && (!(v0_q && v1_q) || bufPop);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      txData <= BYTE_ZERO;
      d1_q <= BYTE_ZERO;
    end else if (bufPop) begin
      if (v1_q) begin
        txData <= d1_q;
        v1_q <= bufPush;
        d1_q <= inByte;
      end else begin
        v0_q <= bufPush;
        txData <= inByte;
      end
    end else if (bufPush) begin
      if (!v0_q) begin
        v0_q <= 1'b1;
        txData <= inByte;
      end else begin
        v1_q <= 1'b1;
        d1_q <= inByte;
      end
    end
  end

  assign txValid = v0_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seqHeaderStrobe;
    headerDone && hdrStrobe;
  endsequence

  sequence seqStrobePulse;
    strobeValid ##1 !strobeValid;
  endsequence

  AST_SO_LOW_AT_SELECT: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
    csFall && !crystalNotReady |=> !serialOut && serialOutOe)
    else $error("serial out not low after select");

  AST_DESELECT_ABANDONS: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
    csS2_q |=> phase_q == PH_IDLE && !serialOutOe && !regWrValid)
    else $error("transfer not abandoned on deselect");

  AST_RW_FIRST_BIT: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
    sclkRise && !csS2_q && !csFall && phase_q == PH_HEADER && bitCnt_q == BIT_FIRST
    |=> rw_q == $past(siS2_q))
    else $error("first header bit not taken as read/write");

  AST_RX_FILL: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    rw_q && rxCount < 7'h0f |-> statusByte[3:0] == rxCount[3:0])
    else $error("receive fill count wrong");

  AST_TX_FILL_SAT: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
    !rw_q && txFreeAdj >= 7'h0f |-> statusByte[3:0] == FILL_MAX)
    else $error("transmit free count not saturated");

  AST_STATE_FIELD: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
    !stateTransitional |-> statusByte[6:4] == radioState)
    else $error("state field differs from radio state");

  AST_STROBE_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n) // [RL24]
    seqHeaderStrobe |=> seqStrobePulse)
    else $error("strobe pulse missing or too long");

  AST_BURST_STEP: assert property (@(posedge clk) disable iff (!rst_n) // [RL23]
    dataDone && burstGo && !addrFifo ##1 !csS2_q |=> regAddr == $past(addr_q, 2) + ADDR_STEP)
    else $error("burst address did not advance");

  AST_WRITE_ADDR_HELD: assert property (@(posedge clk) disable iff (!rst_n) // [RL23]
    cfgWrite |=> regWrValid && regAddr == $past(addr_q))
    else $error("write pulse met a moved address");

  AST_READ_DATA_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [RL26]
    loadRead && !csS2_q |=> !useStatus_q && serialOut == $past(readByte[7]))
    else $error("read data byte not shifted out");

  AST_TX_NO_LOSS: assert property (@(posedge clk) disable iff (!rst_n) // [RL25]
    bufPush && !v0_q |=> txValid && txData == $past(inByte))
    else $error("transmit byte lost");

endmodule
`default_nettype wire

/* dv/spi_host_model.sv */
// Host side of the serial link: drives clock, select and data, reads status.
// Assumes the device answers on serialOut within a few design clocks.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk,
  output logic serialClk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  // ************************************************
  // Serial transfers
  // ************************************************
  // The clock stands low between frames, as a real master leaves it.
  initial begin
    {serialClk, chipSelectN, serialIn} = 3'b010;
  end

  // Waits at most 40 cycles; the quarter step keeps later edges off the clk edges.
  task automatic select(output int n);
    n = 0;
    chipSelectN = 1'b0;
    while ((serialOutOe !== 1'b1 || serialOut !== 1'b0) && n < 40) begin
      @(posedge clk);
      n++;
    end
    #0.25;
  endtask

  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      serialIn = tx[i];
      #62.5;
      serialClk = 1'b1;
      rx[i] = serialOut;
      #62.5;
      serialClk = 1'b0;
    end
  endtask

  // A released data line shows the inverse, so stale bits are never mistaken.
  task automatic deselect();
    #62.5;
    chipSelectN = 1'b1;
    serialIn = ~serialIn;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/radio_spi_slave_status_test.sv */
// Self-checking bench for the radio serial slave, with a host model on the link.
// Assumes the design package is compiled first; the core side is driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH at %0t got %h exp %h", $time, (got), (exp)); end end
module radio_spi_slave_status_test;
  import radio_spi_pkg::*;
  logic clk, rst_n, serialClk, chipSelectN, serialIn, serialOut, serialOutOe;
  logic crystalNotReady, stateTransitional, regWrValid, strobeValid, rxValid, rxReady;
  logic txValid, txReady;
  radio_state_t radioState;
  logic [6:0] rxCount, txFree;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, rxData, txData, s0, s1, s2;
  logic [13:0] writes[$];
  logic [7:0] popped[$];
  int mismatches = 0, checksDone = 0, cycles = 0, strobes = 0, pops = 0, n;

  radio_spi_slave_status uut (.clk, .rst_n, .serialClk, .chipSelectN, .serialIn,
    .serialOut, .serialOutOe, .crystalNotReady, .radioState, .stateTransitional,
    .rxCount, .txFree, .regAddr, .regWrValid, .regWrData, .regRdData, .strobeValid,
    .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady);
  spi_host_model host (.clk, .serialClk, .chipSelectN, .serialIn, .serialOut, .serialOutOe);

  // ************************************************
  // Clock, monitor and verdict
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (regWrValid === 1'b1) writes.push_back({regAddr, regWrData});
    if (strobeValid === 1'b1) strobes++;
    if (rxReady === 1'b1) pops++;
    if (txValid === 1'b1 && txReady === 1'b1) popped.push_back(txData);
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic xact(input logic [7:0] hdr, input logic [7:0] d, input int nb);
    host.select(n);
    host.xfer(hdr, 8, s0);
    host.xfer(d, nb, s1);
    host.deselect();
  endtask

  task automatic t_states();
    txFree = 7'd9;
    for (int k = 0; k < 8; k++) begin
      radioState = radio_state_t'(k);
      xact(8'h30, 8'h00, 0);
      `CHK(s0, {1'b0, 3'(k), 4'h9})
    end
    `CHK(strobes, 8)
    radioState = ST_SETTLING;
    stateTransitional = 1'b1;
    xact(8'h30, 8'h00, 0);
    `CHK(s0[6:4], ST_IDLE)
    stateTransitional = 1'b0;
    radioState = ST_IDLE;
  endtask

  task automatic t_fill();
    int e;
    for (int i = 0; i < 5; i++) begin
      rxCount = 7'(13 + i);
      txFree = 7'(17 - i);
      e = i[0] ? 13 + i : 17 - i;
      if (e > 15) e = 15;
      xact({i[0], 7'h30}, 8'h00, 0);
      `CHK(s0[3:0], 4'(e))
    end
  endtask

  task automatic t_crystal();
    crystalNotReady = 1'b1;
    host.select(n);
    `CHK(n, 40)
    `CHK({serialOutOe, serialOut}, 2'b11)
    @(negedge clk);
    crystalNotReady = 1'b0;
    host.select(n);
    `CHK(n < 6, 1'b1)
    host.xfer(8'h30, 8, s0);
    host.deselect();
    `CHK(s0[7], 1'b0)
  endtask

  // Writes, a read, a burst, a burst into the status range and two aborts.
  task automatic t_regs();
    regRdData = 8'h3c;
    txFree = 7'd4;
    strobes = 0;
    xact(8'h05, 8'ha5, 8);
    `CHK(s1, 8'h04)
    xact(8'h85, 8'h00, 8);
    `CHK(s1, 8'h3c)
    host.select(n);
    host.xfer(8'h41, 8, s0);
    host.xfer(8'h11, 8, s1);
    host.xfer(8'h22, 8, s1);
    host.deselect();
    xact(8'h70, 8'h33, 8);
    xact(8'h06, 8'h5a, 4);
    host.select(n);
    host.xfer(8'h31, 5, s0);
    host.deselect();
    `CHK(strobes, 0)
    `CHK(writes.size(), 3)
    `CHK({writes[0], writes[1], writes[2]}, {6'h05, 8'ha5, 6'h01, 8'h11, 6'h02, 8'h22})
  endtask

  // The consumer stalls while the host overfills the two-entry buffer.
  task automatic t_tx();
    txFree = 7'd2;
    host.select(n);
    host.xfer(8'h7f, 8, s0);
    host.xfer(8'ha1, 8, s0);
    host.xfer(8'ha2, 8, s1);
    host.xfer(8'ha3, 8, s2);
    host.deselect();
    `CHK({s0[3:0], s1[3:0], s2[3:0]}, 12'h210)
    `CHK({txValid, txData}, 9'h1a1)
    txReady = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(popped.size(), 2)
    `CHK({popped[0], popped[1], txValid}, {8'ha1, 8'ha2, 1'b0})
  endtask

  task automatic t_rx();
    {rxValid, rxData, rxCount} = {1'b1, 8'h77, 7'd1};
    radioState = ST_RX_OVERRUN;
    xact(8'hbf, 8'h00, 8);
    `CHK({s0[6:0], s1}, 15'h6177)
    `CHK(pops, 1)
    xact(8'h3d, 8'h00, 0);
    `CHK(strobes, 1)
    radioState = ST_IDLE;
  endtask

  initial begin
    rst_n = 1'b0;
    {crystalNotReady, stateTransitional, rxValid, txReady} = 4'h0;
    radioState = ST_IDLE;
    {rxCount, txFree, regRdData, rxData} = 30'h0;
    repeat (10) @(negedge clk);
    `CHK({serialOutOe, regWrValid, strobeValid, txValid, rxReady, regAddr}, 11'h000)
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_states();
    t_fill();
    t_crystal();
    t_regs();
    t_tx();
    t_rx();
    close_out();
  end
endmodule
`default_nettype wire
